// file: src/lqcsr_consts.svh
`ifndef LQCSR_CONSTS_SVH
`define LQCSR_CONSTS_SVH

// host port byte addresses of the four registers
`define LQCSR_ISO_RX_CONTROL_OFS 8'h54
`define LQCSR_ISO_RX_BUFFER_STATUS_OFS 8'h58
`define LQCSR_ASYNC_CONTROL_OFS 8'h80
`define LQCSR_ASYNC_QUEUE_STATUS_OFS 8'h84

// iso_rx_control fields
`define LQCSR_ISO_SPEED_LSB 16
`define LQCSR_ISO_TAG_LSB 14
`define LQCSR_ISO_LISTEN_STREAM_NUMBER_LSB 8
`define LQCSR_ISO_ERR_LSB 4
`define LQCSR_ISO_SY_LSB 0
`define LQCSR_ISO_CTRL_WMASK 32'h0000FF00

// async_control fields
`define LQCSR_ASYNC_RXCLR_BIT 22
`define LQCSR_ASYNC_TXCLR_BIT 21
`define LQCSR_ASYNC_ACCEPT_ALL_BIT 20
`define LQCSR_ASYNC_RETRY_LSB 16
`define LQCSR_ASYNC_TOS_LSB 13
`define LQCSR_ASYNC_TOF_LSB 0
`define LQCSR_ASYNC_CTRL_WMASK 32'h007FFFFF

// async_queue_status fields
`define LQCSR_TX_RESP_IDLE_BIT 17
`define LQCSR_TX_REQ_IDLE_BIT 16
`define LQCSR_RX_RESP_FLAGS_LSB 12
`define LQCSR_RX_REQ_FLAGS_LSB 8
`define LQCSR_TX_RESP_FLAGS_LSB 4
`define LQCSR_TX_REQ_FLAGS_LSB 0

// flag nibble layout: full, almost full, five free, empty
`define LQCSR_FLAG_FULL_BIT 3
`define LQCSR_FLAG_AFULL_BIT 2
`define LQCSR_FLAG_FIVE_BIT 1
`define LQCSR_FLAG_EMPTY_BIT 0
`define LQCSR_FIVE_FREE_MIN 5

// error codes
`define LQCSR_ERR_ACK_COMPLETE 4'h1
`define LQCSR_ERR_ACK_DATA_ERROR 4'hD

// reset values
`define LQCSR_ISO_RX_CONTROL_RST 32'h00000000
`define LQCSR_ISO_BUF_RST_FLAGS 4'h3
`define LQCSR_ASYNC_CTRL_RST 32'h00000000
`define LQCSR_ASYNC_Q_RST_FLAGS 4'h0
`define LQCSR_ASYNC_QUEUE_STATUS_RST 32'h00000000

// timing
`define LQCSR_CLK_PERIOD_NS 10
`define LQCSR_FRAC_TICK_NS 125000
`define LQCSR_FRACS_PER_SEC 16'h1F40

`endif

// file: src/lqcsr_fill_track.sv
`timescale 1ns/1ps
`include "lqcsr_consts.svh"
module lqcsr_fill_track
	import lqcsr_pkg::*;
#(
	parameter int DEPTH = 32,
	parameter lqcsr_flags_t RESET_FLAGS = 4'h0
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic clear_in,
	input wire logic push_in,
	input wire logic pop_in,
	output lqcsr_flags_t flags_out
);
	localparam int CW = $clog2(DEPTH + 1);

	generate
		if (DEPTH < 2) begin : g_bad_depth
			$error("lqcsr_fill_track: DEPTH must be at least 2");
		end
	endgenerate

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic [CW-1:0] free_slots;
	wire do_push = push_in && (count != CW'(DEPTH));
	wire do_pop = pop_in && (count != '0);
	lqcsr_flags_t next_flags;

	assign next_count = clear_in ? '0 : count + CW'(do_push) - CW'(do_pop);
	assign free_slots = CW'(DEPTH) - next_count;
	// flags come from the count of the same edge, so they lag no access
	assign next_flags[`LQCSR_FLAG_FULL_BIT] = (free_slots == '0);
	assign next_flags[`LQCSR_FLAG_AFULL_BIT] = (free_slots == CW'(1));
	assign next_flags[`LQCSR_FLAG_FIVE_BIT] = (32'(free_slots) >= `LQCSR_FIVE_FREE_MIN);
	assign next_flags[`LQCSR_FLAG_EMPTY_BIT] = (next_count == '0);

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			count <= '0;
			flags_out <= RESET_FLAGS;
		end else if (clk_en_in) begin
			count <= next_count;
			flags_out <= next_flags;
		end
	end
endmodule

// file: src/lqcsr_pkg.sv
package lqcsr_pkg;
	typedef enum logic {LQCSR_TMR_IDLE, LQCSR_TMR_RUN} lqcsr_timer_e;
	typedef logic [3:0] lqcsr_flags_t;
	typedef logic [31:0] lqcsr_word_t;
endpackage

// file: src/lqcsr_regs.sv
`timescale 1ns/1ps
`include "lqcsr_consts.svh"
// Overview of operation
// - last accepted iso packet speed reads in two bits: 00/01/10 for 100/200/400.
// - iso packets are taken only when their tag equals the written tag setting.
// - iso packets are taken only on the written listen channel.
// - last iso packet error code: 0001 complete, 1101 data error.
// - data error only for block payload with bad CRC or length mismatch.
// - sy code of the last accepted iso packet is captured read-only.
// - iso buffer full flag when no quadlet space remains.
// - iso buffer almost-full flag exactly when one quadlet remains.
// - iso buffer five-free flag when at least five quadlets are free.
// - iso buffer empty flag when nothing committed; status resets to 0x3.
// - writing one clears the async receiver; bit self-clears when link is idle.
// - async transmitter held in reset while its bit is set.
// - while receiver clear is off, responses stored all when accept-all set, else only solicited ones.
// - transmitter single-phase retries never exceed the retry limit field.
// - timeout is whole seconds plus eight-thousandths of a second.
// - unused async queue status bits read zero; register is read-only.
// - tx response and request idle flags while transfer register is empty.
// - rx response queue shows full, almost full, five free, empty.
// - rx request queue shows full, almost full, five free, empty.
// - tx response queue shows full, almost full, five free, empty.
// - tx request queue shows the four flags in the lowest status bits.
// - missing solicited response within timeout raises a timeout event.
module lqcsr_regs
	import lqcsr_pkg::*;
#(
	parameter int ISO_DEPTH = 64,
	parameter int RX_RESP_DEPTH = 32,
	parameter int RX_REQ_DEPTH = 32,
	parameter int TX_RESP_DEPTH = 32,
	parameter int TX_REQ_DEPTH = 32,
	parameter int FRAC_TICK_CYCLES = `LQCSR_FRAC_TICK_NS / `LQCSR_CLK_PERIOD_NS
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	// byte-wide host port, pins
	input wire logic host_cs_n_in,
	input wire logic host_rd_n_in,
	input wire logic host_wr_n_in,
	input wire logic [7:0] host_addr_in,
	input wire logic [7:0] host_wdata_in,
	output logic [7:0] host_rdata_out,
	// iso receive packet engine
	input wire logic iso_pkt_done_in,
	input wire logic [1:0] iso_pkt_tag_in,
	input wire logic [5:0] iso_pkt_listen_stream_number_in,
	input wire logic [1:0] iso_pkt_speed_in,
	input wire logic [3:0] iso_pkt_sy_in,
	input wire logic iso_pkt_has_block_in,
	input wire logic iso_pkt_crc_ok_in,
	input wire logic iso_pkt_len_ok_in,
	output logic iso_pkt_accept_out,
	input wire logic iso_buf_push_in,
	input wire logic iso_buf_pop_in,
	// async queues
	input wire logic rx_resp_push_in,
	input wire logic rx_resp_pop_in,
	input wire logic rx_req_push_in,
	input wire logic rx_req_pop_in,
	input wire logic tx_resp_push_in,
	input wire logic tx_resp_pop_in,
	input wire logic tx_req_push_in,
	input wire logic tx_req_pop_in,
	input wire logic tx_resp_xfer_loaded_in,
	input wire logic tx_req_xfer_loaded_in,
	// link engines
	input wire logic link_sm_idle_in,
	output logic async_receiver_clear_out,
	output logic async_transmitter_clear_out,
	input wire logic resp_pkt_in,
	input wire logic resp_solicited_in,
	output logic resp_store_out,
	input wire logic tx_new_pkt_in,
	input wire logic tx_retry_req_in,
	output logic tx_retry_grant_out,
	output logic tx_retry_exhausted_out,
	input wire logic split_start_in,
	output logic split_timeout_out
);
	localparam int FW = (FRAC_TICK_CYCLES > 1) ? $clog2(FRAC_TICK_CYCLES) : 1;
	localparam int NQ = 5;
	localparam int DEPTHS [NQ] = '{ISO_DEPTH, RX_RESP_DEPTH, RX_REQ_DEPTH,
		TX_RESP_DEPTH, TX_REQ_DEPTH};

	generate
		if (FRAC_TICK_CYCLES < 1) begin : g_bad_tick
			$error("lqcsr_regs: FRAC_TICK_CYCLES must be at least 1");
		end
	endgenerate

	function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] ofs);
		word_hit = (addr[7:2] == ofs[7:2]);
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old_word,
		input logic [31:0] mask, input logic [31:0] data);
		lane_merge = (old_word & ~mask) | (data & mask);
	endfunction

	// host strobe synchroniser: three stages, a change counts once stages 2 and 3 agree
	logic [1:0] stb_s1;
	logic [1:0] stb_s2;
	logic [1:0] stb_s3;
	logic [1:0] stb_filt;
	logic [1:0] stb_filt_d;
	// address and data pins take the same three stages; they are read only once the
	// strobe has settled, when stages two and three already hold the same value
	logic [15:0] bus_s1;
	logic [15:0] bus_s2;
	logic [15:0] bus_s3;
	wire [7:0] bus_addr = bus_s3[15:8];
	wire [7:0] bus_wdata = bus_s3[7:0];
	wire [1:0] stb_raw = {~host_cs_n_in & ~host_wr_n_in, ~host_cs_n_in & ~host_rd_n_in};
	wire [1:0] next_stb_filt = (stb_s2 & stb_s3) | (stb_filt & (stb_s2 ^ stb_s3));
	wire rd_stb = stb_filt[0] & ~stb_filt_d[0];
	wire wr_stb = stb_filt[1] & ~stb_filt_d[1];

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			stb_s1 <= 2'h0;
			stb_s2 <= 2'h0;
			stb_s3 <= 2'h0;
			stb_filt <= 2'h0;
			stb_filt_d <= 2'h0;
			bus_s1 <= 16'h0000;
			bus_s2 <= 16'h0000;
			bus_s3 <= 16'h0000;
		end else if (clk_en_in) begin
			stb_s1 <= stb_raw;
			stb_s2 <= stb_s1;
			stb_s3 <= stb_s2;
			stb_filt <= next_stb_filt;
			stb_filt_d <= stb_filt;
			bus_s1 <= {host_addr_in, host_wdata_in};
			bus_s2 <= bus_s1;
			bus_s3 <= bus_s2;
		end
	end

	// byte-lane write decode
	wire [31:0] lane_mask = 32'h000000FF << {bus_addr[1:0], 3'h0};
	wire [31:0] lane_data = {24'h000000, bus_wdata} << {bus_addr[1:0], 3'h0};
	wire wr_iso_ctrl = wr_stb && word_hit(bus_addr, `LQCSR_ISO_RX_CONTROL_OFS);
	wire wr_async_ctrl = wr_stb && word_hit(bus_addr, `LQCSR_ASYNC_CONTROL_OFS);

	// iso_rx_control
	lqcsr_word_t iso_ctrl;
	wire [1:0] tag_setting = iso_ctrl[`LQCSR_ISO_TAG_LSB +: 2];
	wire [5:0] listen_stream_number = iso_ctrl[`LQCSR_ISO_LISTEN_STREAM_NUMBER_LSB +: 6];
	wire iso_match = iso_pkt_done_in && (iso_pkt_tag_in == tag_setting)
		&& (iso_pkt_listen_stream_number_in == listen_stream_number);
	wire iso_data_bad = iso_pkt_has_block_in && !(iso_pkt_crc_ok_in && iso_pkt_len_ok_in);
	wire [3:0] iso_err_code = iso_data_bad ? `LQCSR_ERR_ACK_DATA_ERROR
		: `LQCSR_ERR_ACK_COMPLETE;
	wire [31:0] iso_wr_word = lane_merge(iso_ctrl, lane_mask, lane_data);
	wire [31:0] iso_ctrl_wr = wr_iso_ctrl
		? ((iso_wr_word & `LQCSR_ISO_CTRL_WMASK) | (iso_ctrl & ~`LQCSR_ISO_CTRL_WMASK))
		: iso_ctrl;
	wire [31:0] iso_capture = {14'h0000, iso_pkt_speed_in, 8'h00, iso_err_code, iso_pkt_sy_in};
	wire [31:0] iso_ro_mask = 32'h00030000 | (32'h0000000F << `LQCSR_ISO_ERR_LSB)
		| (32'h0000000F << `LQCSR_ISO_SY_LSB);
	wire [31:0] next_iso_ctrl = iso_match
		? ((iso_ctrl_wr & ~iso_ro_mask) | (iso_capture & iso_ro_mask))
		: iso_ctrl_wr;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			iso_ctrl <= `LQCSR_ISO_RX_CONTROL_RST;
			iso_pkt_accept_out <= 1'b0;
		end else if (clk_en_in) begin
			iso_ctrl <= next_iso_ctrl;
			iso_pkt_accept_out <= iso_match;
		end
	end

	// async_control
	lqcsr_word_t async_ctrl;
	wire [31:0] async_wr_word = lane_merge(async_ctrl, lane_mask, lane_data)
		& `LQCSR_ASYNC_CTRL_WMASK;
	wire [31:0] async_ctrl_wr = wr_async_ctrl ? async_wr_word : async_ctrl;
	// a write to another lane must not re-arm a receiver clear that is still pending
	wire rxclr_set = wr_async_ctrl && lane_mask[`LQCSR_ASYNC_RXCLR_BIT]
		&& lane_data[`LQCSR_ASYNC_RXCLR_BIT];
	// a fresh set beats the idle self-clear in the same cycle
	wire next_rxclr = rxclr_set || (async_ctrl_wr[`LQCSR_ASYNC_RXCLR_BIT] && !link_sm_idle_in);
	wire [31:0] next_async_ctrl = {async_ctrl_wr[31:23], next_rxclr, async_ctrl_wr[21:0]};
	wire accept_all_responses = async_ctrl[`LQCSR_ASYNC_ACCEPT_ALL_BIT];
	wire [3:0] retry_limit = async_ctrl[`LQCSR_ASYNC_RETRY_LSB +: 4];
	wire [2:0] timeout_whole_seconds = async_ctrl[`LQCSR_ASYNC_TOS_LSB +: 3];
	wire [12:0] timeout_fraction_ticks = async_ctrl[`LQCSR_ASYNC_TOF_LSB +: 13];
	wire async_receiver_clear = async_ctrl[`LQCSR_ASYNC_RXCLR_BIT];
	wire async_transmitter_clear = async_ctrl[`LQCSR_ASYNC_TXCLR_BIT];

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			async_ctrl <= `LQCSR_ASYNC_CTRL_RST;
			async_receiver_clear_out <= 1'b0;
			async_transmitter_clear_out <= 1'b0;
		end else if (clk_en_in) begin
			async_ctrl <= next_async_ctrl;
			async_receiver_clear_out <= next_async_ctrl[`LQCSR_ASYNC_RXCLR_BIT];
			async_transmitter_clear_out <= next_async_ctrl[`LQCSR_ASYNC_TXCLR_BIT];
		end
	end

	// response filter
	wire next_resp_store = resp_pkt_in && !async_receiver_clear
		&& (accept_all_responses || resp_solicited_in);

	// retry limiter
	logic [3:0] retry_count;
	wire retry_ok = (retry_count < retry_limit);
	wire retry_grant = tx_retry_req_in && !async_transmitter_clear && retry_ok;
	wire retry_deny = tx_retry_req_in && !async_transmitter_clear && !retry_ok;
	wire [3:0] next_retry_count = (async_transmitter_clear || tx_new_pkt_in) ? 4'h0
		: retry_count + {3'h0, retry_grant};

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			retry_count <= 4'h0;
			resp_store_out <= 1'b0;
			tx_retry_grant_out <= 1'b0;
			tx_retry_exhausted_out <= 1'b0;
		end else if (clk_en_in) begin
			retry_count <= next_retry_count;
			resp_store_out <= next_resp_store;
			tx_retry_grant_out <= retry_grant;
			tx_retry_exhausted_out <= retry_deny;
		end
	end

	// split-transaction timer, counts eighth-millisecond ticks up to the programmed total
	lqcsr_timer_e tmr_state;
	lqcsr_timer_e next_tmr_state;
	logic [FW-1:0] frac_cnt;
	logic [15:0] tick_cnt;
	logic [15:0] tick_target;
	wire frac_wrap = (frac_cnt == FW'(FRAC_TICK_CYCLES - 1));
	wire solicited_seen = resp_pkt_in && resp_solicited_in;
	wire [15:0] start_target = 16'(timeout_whole_seconds) * `LQCSR_FRACS_PER_SEC
		+ 16'(timeout_fraction_ticks);
	wire tmr_expire = (tmr_state == LQCSR_TMR_RUN) && (tick_cnt >= tick_target)
		&& !solicited_seen;

	always_comb begin
		next_tmr_state = tmr_state;
		unique case (tmr_state)
			LQCSR_TMR_IDLE: begin
				if (split_start_in && !async_transmitter_clear) begin
					next_tmr_state = LQCSR_TMR_RUN;
				end
			end
			LQCSR_TMR_RUN: begin
				if (async_transmitter_clear || solicited_seen || tmr_expire) begin
					next_tmr_state = LQCSR_TMR_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			tmr_state <= LQCSR_TMR_IDLE;
			frac_cnt <= '0;
			tick_cnt <= 16'h0000;
			tick_target <= 16'h0000;
			split_timeout_out <= 1'b0;
		end else if (clk_en_in) begin
			tmr_state <= next_tmr_state;
			split_timeout_out <= tmr_expire;
			if (tmr_state == LQCSR_TMR_IDLE) begin
				frac_cnt <= '0;
				tick_cnt <= 16'h0000;
				tick_target <= start_target;
			end else begin
				frac_cnt <= frac_wrap ? '0 : frac_cnt + FW'(1);
				tick_cnt <= tick_cnt + {15'h0000, frac_wrap};
			end
		end
	end

	// fill trackers: iso buffer, rx resp, rx req, tx resp, tx req
	wire [NQ-1:0] q_push = {tx_req_push_in, tx_resp_push_in, rx_req_push_in,
		rx_resp_push_in, iso_buf_push_in};
	wire [NQ-1:0] q_pop = {tx_req_pop_in, tx_resp_pop_in, rx_req_pop_in,
		rx_resp_pop_in, iso_buf_pop_in};
	wire [NQ-1:0] q_clear = {async_transmitter_clear, async_transmitter_clear,
		async_receiver_clear, async_receiver_clear, 1'b0};
	lqcsr_flags_t q_flags [NQ];

	genvar qi;
	generate
		for (qi = 0; qi < NQ; qi++) begin : g_fill
			lqcsr_fill_track #(
				.DEPTH(DEPTHS[qi]),
				.RESET_FLAGS((qi == 0) ? `LQCSR_ISO_BUF_RST_FLAGS : `LQCSR_ASYNC_Q_RST_FLAGS)
			) u_fill (
				.sys_clk_in(sys_clk_in),
				.rst_n_in(rst_n_in),
				.clk_en_in(clk_en_in),
				.clear_in(q_clear[qi]),
				.push_in(q_push[qi]),
				.pop_in(q_pop[qi]),
				.flags_out(q_flags[qi])
			);
		end
	endgenerate

	// transfer-register idle flags
	logic tx_resp_xfer_empty;
	logic tx_req_xfer_empty;
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			tx_resp_xfer_empty <= 1'b0;
			tx_req_xfer_empty <= 1'b0;
		end else if (clk_en_in) begin
			tx_resp_xfer_empty <= !tx_resp_xfer_loaded_in;
			tx_req_xfer_empty <= !tx_req_xfer_loaded_in;
		end
	end

	wire [31:0] iso_buf_word = {28'h0000000, q_flags[0]};
	wire [31:0] async_q_word = {14'h0000, tx_resp_xfer_empty, tx_req_xfer_empty,
		q_flags[1], q_flags[2], q_flags[3], q_flags[4]};

	// read path, unmapped addresses read zero
	wire [31:0] rd_word = word_hit(bus_addr, `LQCSR_ISO_RX_CONTROL_OFS) ? iso_ctrl
		: word_hit(bus_addr, `LQCSR_ISO_RX_BUFFER_STATUS_OFS) ? iso_buf_word
		: word_hit(bus_addr, `LQCSR_ASYNC_CONTROL_OFS) ? async_ctrl
		: word_hit(bus_addr, `LQCSR_ASYNC_QUEUE_STATUS_OFS) ? async_q_word
		: 32'h00000000;
	wire [31:0] rd_shift = rd_word >> {bus_addr[1:0], 3'h0};

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			host_rdata_out <= 8'h00;
		end else if (clk_en_in && rd_stb) begin
			host_rdata_out <= rd_shift[7:0];
		end
	end
endmodule

// file: test/lqcsr_host_model.sv
`timescale 1ns/1ps
module lqcsr_host_model (
	input wire logic sys_clk_in,
	input wire logic [7:0] host_rdata_in,
	output logic host_cs_n_out,
	output logic host_rd_n_out,
	output logic host_wr_n_out,
	output logic [7:0] host_addr_out,
	output logic [7:0] host_wdata_out
);
	initial begin
		host_cs_n_out = 1'b1;
		host_rd_n_out = 1'b1;
		host_wr_n_out = 1'b1;
		host_addr_out = 8'h00;
		host_wdata_out = 8'h00;
	end
	// strobe held seven cycles: the port lands a byte after five, the rest is margin
	task automatic access(input logic is_wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge sys_clk_in);
		host_cs_n_out <= 1'b0;
		host_rd_n_out <= is_wr;
		host_wr_n_out <= !is_wr;
		host_addr_out <= a;
		host_wdata_out <= d;
		repeat (7) @(posedge sys_clk_in);
		q = host_rdata_in;
		host_cs_n_out <= 1'b1;
		host_rd_n_out <= 1'b1;
		host_wr_n_out <= 1'b1;
		// released lines do not keep their last value
		host_addr_out <= ~a;
		host_wdata_out <= ~d;
		repeat (3) @(posedge sys_clk_in);
	endtask
endmodule

// file: test/lqcsr_regs_monitor.sv
`timescale 1ns/1ps
module lqcsr_regs_monitor (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic host_wr_n_in,
	input wire logic iso_pkt_done_in,
	input wire logic iso_pkt_accept_out,
	input wire logic resp_pkt_in,
	input wire logic resp_solicited_in,
	input wire logic resp_store_out,
	input wire logic link_sm_idle_in,
	input wire logic async_receiver_clear_out,
	input wire logic async_transmitter_clear_out,
	input wire logic tx_retry_req_in,
	input wire logic tx_retry_grant_out,
	input wire logic tx_retry_exhausted_out,
	input wire logic split_timeout_out
);
	default clocking mon_cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// six quiet cycles cover the host write pipeline, so no fresh set is in flight
	sequence quiet_idle_s;
		(link_sm_idle_in && host_wr_n_in) [*6];
	endsequence
	sequence solicited_resp_s;
		resp_pkt_in && resp_solicited_in && !async_receiver_clear_out
			&& !$past(async_receiver_clear_out);
	endsequence
	AST_ACCEPT_CAUSE: assert property (iso_pkt_accept_out |-> $past(iso_pkt_done_in))
		else $error("iso accept without a packet");
	AST_STORE_CAUSE: assert property (resp_store_out |-> $past(resp_pkt_in))
		else $error("response stored without a packet");
	AST_STORE_SOLICITED: assert property (solicited_resp_s |=> resp_store_out)
		else $error("solicited response not stored");
	AST_RETRY_CAUSE: assert property ((tx_retry_grant_out || tx_retry_exhausted_out)
		|-> $past(tx_retry_req_in))
		else $error("retry answer without request");
	AST_RETRY_ANSWER: assert property (tx_retry_req_in && !async_transmitter_clear_out
		&& !$past(async_transmitter_clear_out) |=> tx_retry_grant_out != tx_retry_exhausted_out)
		else $error("retry request not answered once");
	AST_TXCLR_SILENT: assert property (async_transmitter_clear_out
		&& $past(async_transmitter_clear_out) |-> !tx_retry_grant_out && !tx_retry_exhausted_out)
		else $error("retry answered while transmitter cleared");
	AST_RXCLR_AUTO: assert property (quiet_idle_s |-> !async_receiver_clear_out)
		else $error("receiver clear stuck while idle");
	AST_TIMEOUT_PULSE: assert property (split_timeout_out |=> !split_timeout_out)
		else $error("timeout event longer than one cycle");
endmodule

bind lqcsr_regs lqcsr_regs_monitor u_monitor (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .host_wr_n_in(host_wr_n_in),
	.iso_pkt_done_in(iso_pkt_done_in), .iso_pkt_accept_out(iso_pkt_accept_out),
	.resp_pkt_in(resp_pkt_in), .resp_solicited_in(resp_solicited_in),
	.resp_store_out(resp_store_out), .link_sm_idle_in(link_sm_idle_in),
	.async_receiver_clear_out(async_receiver_clear_out),
	.async_transmitter_clear_out(async_transmitter_clear_out),
	.tx_retry_req_in(tx_retry_req_in), .tx_retry_grant_out(tx_retry_grant_out),
	.tx_retry_exhausted_out(tx_retry_exhausted_out), .split_timeout_out(split_timeout_out)
);

// file: test/tb_link_queue_control_status_regs.sv
`timescale 1ns/1ps
module tb_link_queue_control_status_regs;
	import lqcsr_pkg::*;
	localparam int DEPTH = 8;
	logic sys_clk_in;
	logic rst_n_in;
	logic en;
	logic cs_n, rd_n, wr_n, idle, accept, rxclr, txclr, store, grant, exh, split_to, seen;
	logic [7:0] addr, wdata, rdata, b;
	logic [17:0] pkt;
	logic [14:0] stim;
	logic [1:0] loaded;
	lqcsr_word_t w;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	lqcsr_regs #(.ISO_DEPTH(DEPTH), .RX_RESP_DEPTH(DEPTH), .RX_REQ_DEPTH(DEPTH),
		.TX_RESP_DEPTH(DEPTH), .TX_REQ_DEPTH(DEPTH), .FRAC_TICK_CYCLES(4)) u_dut (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(en),
		.host_cs_n_in(cs_n), .host_rd_n_in(rd_n), .host_wr_n_in(wr_n),
		.host_addr_in(addr), .host_wdata_in(wdata), .host_rdata_out(rdata),
		.iso_pkt_done_in(pkt[17]), .iso_pkt_tag_in(pkt[16:15]),
		.iso_pkt_listen_stream_number_in(pkt[14:9]), .iso_pkt_speed_in(pkt[8:7]), .iso_pkt_sy_in(pkt[6:3]),
		.iso_pkt_has_block_in(pkt[2]), .iso_pkt_crc_ok_in(pkt[1]), .iso_pkt_len_ok_in(pkt[0]),
		.iso_pkt_accept_out(accept), .iso_buf_push_in(stim[0]), .rx_resp_push_in(stim[1]),
		.rx_req_push_in(stim[2]), .tx_resp_push_in(stim[3]), .tx_req_push_in(stim[4]),
		.iso_buf_pop_in(stim[5]), .rx_resp_pop_in(stim[6]), .rx_req_pop_in(stim[7]),
		.tx_resp_pop_in(stim[8]), .tx_req_pop_in(stim[9]), .tx_new_pkt_in(stim[10]),
		.tx_retry_req_in(stim[11]), .resp_pkt_in(stim[12]), .split_start_in(stim[13]),
		.resp_solicited_in(stim[14]), .tx_resp_xfer_loaded_in(loaded[1]),
		.tx_req_xfer_loaded_in(loaded[0]), .link_sm_idle_in(idle),
		.async_receiver_clear_out(rxclr), .async_transmitter_clear_out(txclr),
		.resp_store_out(store), .tx_retry_grant_out(grant), .tx_retry_exhausted_out(exh),
		.split_timeout_out(split_to));
	lqcsr_host_model u_host (.sys_clk_in(sys_clk_in), .host_rdata_in(rdata),
		.host_cs_n_out(cs_n), .host_rd_n_out(rd_n), .host_wr_n_out(wr_n),
		.host_addr_out(addr), .host_wdata_out(wdata));
	task automatic check(input string what, input lqcsr_word_t seen_v, input lqcsr_word_t exp);
		total_checks++;
		if (seen_v !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen_v);
		end
	endtask
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_host.access(1'b1, a, d, q);
	endtask
	task automatic rd32(input logic [7:0] a, output lqcsr_word_t v);
		logic [7:0] q;
		for (int i = 0; i < 4; i++) begin
			u_host.access(1'b0, a + i[7:0], 8'h00, q);
			v[8*i +: 8] = q;
		end
	endtask
	task automatic pulse(input logic [14:0] m);
		@(posedge sys_clk_in);
		stim <= m;
		@(posedge sys_clk_in);
		stim <= '0;
		#1;
	endtask
	task automatic check_q(input int q, input int c);
		lqcsr_flags_t f;
		f = {c == DEPTH, c == DEPTH - 1, DEPTH - c >= 5, c == 0};
		u_host.access(1'b0, q == 0 ? 8'h58 : (q < 3 ? 8'h85 : 8'h84), 8'h00, b);
		check("queue flags", b, q == 0 ? {4'h0, f} : (q % 2 ? {f, 4'h3} : {4'h3, f}));
	endtask
	task automatic pkt_case(input logic [16:0] f, input logic acc, input lqcsr_word_t exp);
		@(posedge sys_clk_in);
		pkt <= {1'b1, f};
		@(posedge sys_clk_in);
		pkt <= {1'b0, ~f};
		#1 check("iso accept", accept, acc);
		rd32(8'h54, w);
		check("iso control", w, exp);
	endtask
	task automatic results();
		if (num_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end
	always @(posedge sys_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			results();
		end
	end
	initial begin
		rst_n_in = 1'b0;
		pkt = '0;
		stim = '0;
		loaded = '0;
		idle = 1'b0;
		en = 1'b1;
		repeat (8) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		rd32(8'h58, w);
		check("iso status", w, 32'h00000003);
		rd32(8'h80, w);
		check("async control", w, 32'h00000000);
		wr8(8'h84, 8'hFF);
		rd32(8'h84, w);
		check("async status", w, 32'h00033333);
		rd32(8'h60, w);
		check("unmapped", w, 32'h00000000);
		for (int i = 0; i < 4; i++) wr8(8'h54 + i[7:0], 8'hFF);
		rd32(8'h54, w);
		check("iso control", w, 32'h0000FF00);
		wr8(8'h55, 8'h45);
		pkt_case({2'h1, 6'h05, 2'h2, 4'hA, 3'b101}, 1'b1, 32'h000245DA);
		pkt_case({2'h1, 6'h06, 2'h1, 4'h3, 3'b111}, 1'b0, 32'h000245DA);
		pkt_case({2'h2, 6'h05, 2'h1, 4'h3, 3'b111}, 1'b0, 32'h000245DA);
		pkt_case({2'h1, 6'h05, 2'h1, 4'h5, 3'b110}, 1'b1, 32'h000145D5);
		pkt_case({2'h1, 6'h05, 2'h0, 4'h7, 3'b000}, 1'b1, 32'h00004517);
		pkt_case({2'h1, 6'h05, 2'h2, 4'h0, 3'b111}, 1'b1, 32'h00024510);
		for (int q = 0; q < 5; q++) begin
			for (int c = 0; c <= DEPTH + 1; c++) begin
				if (c > 0) pulse(15'h0001 << q);
				check_q(q, c > DEPTH ? DEPTH : c);
			end
			for (int c = DEPTH - 1; c >= -1; c--) begin
				pulse(15'h0020 << q);
				check_q(q, c < 0 ? 0 : c);
			end
		end
		en <= 1'b0;
		pulse(15'h0001);
		@(posedge sys_clk_in);
		en <= 1'b1;
		check_q(0, 0);
		loaded <= 2'b10;
		u_host.access(1'b0, 8'h86, 8'h00, b);
		check("idle flags", b, 8'h01);
		loaded <= 2'b01;
		u_host.access(1'b0, 8'h86, 8'h00, b);
		check("idle flags", b, 8'h02);
		wr8(8'h80, 8'h03);
		wr8(8'h81, 8'h00);
		wr8(8'h82, 8'h02);
		rd32(8'h80, w);
		check("async control", w, 32'h00020003);
		pulse(15'h0400);
		for (int i = 0; i < 3; i++) begin
			pulse(15'h0800);
			check("retry grant", grant, i < 2);
			check("retry exhausted", exh, i == 2);
		end
		pulse(15'h0400);
		pulse(15'h0800);
		check("retry grant", grant, 1'b1);
		pulse(15'h1000);
		check("store", store, 1'b0);
		pulse(15'h5000);
		check("store", store, 1'b1);
		wr8(8'h82, 8'h12);
		pulse(15'h1000);
		check("store", store, 1'b1);
		pulse(15'h2000);
		n = 0;
		while (split_to !== 1'b1 && n < 40) begin
			@(posedge sys_clk_in);
			#1 n++;
		end
		check("timeout delay", n >= 9 && n <= 16, 1'b1);
		pulse(15'h2000);
		pulse(15'h5000);
		seen = 1'b0;
		repeat (30) begin
			@(posedge sys_clk_in);
			#1 seen = seen | split_to;
		end
		check("timeout after response", seen, 1'b0);
		pulse(15'h0010);
		wr8(8'h82, 8'h32);
		check("tx clear", txclr, 1'b1);
		pulse(15'h0800);
		check("retry while cleared", grant | exh, 1'b0);
		u_host.access(1'b0, 8'h84, 8'h00, b);
		check("tx queues cleared", b, 8'h33);
		wr8(8'h82, 8'h02);
		check("tx clear", txclr, 1'b0);
		wr8(8'h82, 8'h42);
		check("rx clear", rxclr, 1'b1);
		idle <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		#1 check("rx clear", rxclr, 1'b0);
		u_host.access(1'b0, 8'h82, 8'h00, b);
		check("async control", b, 8'h02);
		results();
	end
endmodule
